/* logic/lse_load_store_exec.sv */
/*
  Load/store execution block: registers, address forming, byte-serial
  single, multiple and string transfers, reversal and reservation.
  Assumes a memory answering reads in the next cycle, and a software port.
*/
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lse_load_store_exec (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_op_valid,
  input  wire lse_pkg::lse_op_e i_op,
  input  wire logic             i_upd,
  input  wire logic             i_idx,
  input  wire logic [4:0]       i_rt,
  input  wire logic [4:0]       i_ra,
  input  wire logic [4:0]       i_rb,
  input  wire logic [15:0]      i_disp,
  input  wire logic [4:0]       i_nb,
  output logic                  o_op_ready,
  output logic                  o_op_done,
  output logic                  o_mem_req,
  output logic                  o_mem_we,
  output logic [31:0]           o_mem_addr,
  output logic [7:0]            o_mem_wdata,
  input  wire logic [7:0]       i_mem_rdata,
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic [31:0]      i_reg_wdata,
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  output logic [31:0]           o_reg_rdata
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_REQ, ST_CAP, ST_FIN
  } lse_state_e;

  lse_state_e       state_r;
  lse_pkg::lse_op_e op_r;
  logic             upd_r, ok_r, so_r, rsv_r;
  logic [4:0]       rt_r, ra_r;
  logic [31:0]      ea_r, acc_r, rdata_r;
  logic [7:0]       n_r, idx_r;
  logic [31:0]      genreg_r [32];
  logic [6:0]       cnt_r;
  logic [3:0]       cond_zero_r;
  logic             accept, is_st, blk, rev, last_c, iss_c, genreg_hit;
  logic [1:0]       lane0, ilane_c, clane_c;
  logic [31:0]      base_c, off_c, ea_c;
  logic [7:0]       n_c, nk_c;
  logic [4:0]       ireg_c, creg_c;

  // Byte lane of transfer byte k; lane 0 is the most significant byte.
  function automatic logic [1:0] lane_f(input logic b, input logic r,
                                        input logic [1:0] l0,
                                        input logic [7:0] k);
    lane_f = b ? k[1:0] : r ? 2'h3 - k[1:0] : l0 + k[1:0];
  endfunction

  // Register holding transfer byte k; numbering wraps past 31.
  function automatic logic [4:0] reg_f(input logic       b,
                                       input logic [4:0] r0,
                                       input logic [7:0] k);
    reg_f = b ? r0 + k[6:2] : r0;
  endfunction

  // Widens a halfword by copying its sign bit.
  function automatic logic [31:0] sign_extend_op(input logic [15:0] v);
    sign_extend_op = {{16{v[15]}}, v};
  endfunction

  // Classes of the operation in progress.
  assign is_st = op_r inside {lse_pkg::OP_ST_B, lse_pkg::OP_ST_H,
                 lse_pkg::OP_ST_W, lse_pkg::OP_ST_HREV, lse_pkg::OP_ST_WREV,
                 lse_pkg::OP_ST_COND, lse_pkg::OP_ST_MULT, lse_pkg::OP_ST_STR};
  assign blk   = op_r inside {lse_pkg::OP_LD_MULT, lse_pkg::OP_ST_MULT,
                 lse_pkg::OP_LD_STR, lse_pkg::OP_ST_STR};
  assign rev   = op_r inside {lse_pkg::OP_LD_HREV, lse_pkg::OP_LD_WREV,
                 lse_pkg::OP_ST_HREV, lse_pkg::OP_ST_WREV};
  assign lane0 = (op_r inside {lse_pkg::OP_LD_BZ, lse_pkg::OP_ST_B})
               ? lse_pkg::LANE_BYTE
               : (op_r inside {lse_pkg::OP_LD_HZ, lse_pkg::OP_LD_HA,
                  lse_pkg::OP_ST_H}) ? lse_pkg::LANE_HALF
               : lse_pkg::LANE_WORD;

  // Effective address of an offered command.
  assign accept = o_op_ready && i_op_valid;
  assign base_c = (i_ra == 5'h00) ? 32'h0000_0000 : genreg_r[i_ra];
  assign off_c  = i_idx ? genreg_r[i_rb]
                : (i_op inside {lse_pkg::OP_LD_STR, lse_pkg::OP_ST_STR})
                ? 32'h0000_0000 : sign_extend_op(i_disp);
  assign ea_c   = base_c + off_c;

  // Byte count of an offered command.
  always_comb begin
    case (i_op)
      lse_pkg::OP_LD_BZ, lse_pkg::OP_ST_B: n_c = lse_pkg::N_BYTE;
      lse_pkg::OP_LD_HZ, lse_pkg::OP_LD_HA, lse_pkg::OP_LD_HREV,
      lse_pkg::OP_ST_H, lse_pkg::OP_ST_HREV: n_c = lse_pkg::N_HALF;
      lse_pkg::OP_ST_COND: n_c = rsv_r ? lse_pkg::N_WORD : 8'h00;
      lse_pkg::OP_LD_MULT, lse_pkg::OP_ST_MULT:
        n_c = {(lse_pkg::NUM_GENREG - {1'b0, i_rt}), 2'b00};
      lse_pkg::OP_LD_STR, lse_pkg::OP_ST_STR:
        n_c = i_idx ? {1'b0, cnt_r}
            : (i_nb == 5'h00) ? lse_pkg::STR_ZERO_BYTES
            : {3'b000, i_nb};
      default: n_c = lse_pkg::N_WORD;
    endcase
  end

  // Next byte to request and the byte now being captured.
  assign last_c  = (idx_r + 8'h01) >= n_r;
  assign nk_c    = (state_r == ST_SETUP) ? 8'h00 : idx_r + 8'h01;
  assign iss_c   = (state_r == ST_SETUP) ? (n_r != 8'h00)
                 : (!last_c && ((state_r == ST_CAP)
                   || (state_r == ST_REQ && is_st)));
  assign ilane_c = lane_f(blk, rev, lane0, nk_c);
  assign ireg_c  = reg_f(blk, rt_r, nk_c);
  assign clane_c = lane_f(blk, rev, lane0, idx_r);
  assign creg_c  = reg_f(blk, rt_r, idx_r);

  // Sequencer: one byte per request, a capture cycle after each read.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      idx_r   <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: if (accept) state_r <= ST_SETUP;
        ST_SETUP: begin
          idx_r   <= 8'h00;
          state_r <= (n_r == 8'h00) ? ST_FIN : ST_REQ;
        end
        ST_REQ: begin
          if (!is_st) begin
            state_r <= ST_CAP;
          end else if (last_c) begin
            state_r <= ST_FIN;
          end else begin
            idx_r <= idx_r + 8'h01;
          end
        end
        ST_CAP: begin
          if (last_c) begin
            state_r <= ST_FIN;
          end else begin
            idx_r   <= idx_r + 8'h01;
            state_r <= ST_REQ;
          end
        end
        ST_FIN: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Command fields latched at acceptance; base is read only here.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      op_r  <= lse_pkg::OP_LD_BZ;
      upd_r <= 1'b0;
      ok_r  <= 1'b0;
      rt_r  <= 5'h00;
      ra_r  <= 5'h00;
      ea_r  <= 32'h0000_0000;
      n_r   <= 8'h00;
    end else if (accept) begin
      op_r  <= i_op;
      upd_r <= i_upd;
      ok_r  <= rsv_r;
      rt_r  <= i_rt;
      ra_r  <= i_ra;
      ea_r  <= ea_c;
      n_r   <= n_c;
    end
  end

  // Memory request port, loaded one cycle ahead of each byte.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 32'h0000_0000;
      o_mem_wdata <= 8'h00;
    end else begin
      o_mem_req <= iss_c;
      if (iss_c) begin
        o_mem_we    <= is_st;
        o_mem_addr  <= ea_r + {24'h00_0000, nk_c};
        o_mem_wdata <= genreg_r[ireg_c][{~ilane_c, 3'b000} +: 8];
      end
    end
  end

  // Assembles single loads; lanes not filled stay zero.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || accept) begin
      acc_r <= 32'h0000_0000;
    end else if (state_r == ST_CAP && !blk) begin
      acc_r[{~clane_c, 3'b000} +: 8] <= i_mem_rdata;
    end
  end

  // General registers; the engine wins over a software write.
  assign genreg_hit = i_reg_wr && (i_reg_addr[7] == 1'b0)
                    && (i_reg_addr[1:0] == 2'b00);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < 32; i++) begin
        genreg_r[i] <= lse_pkg::GENREG_RST;
      end
    end else begin
      if (genreg_hit) begin
        genreg_r[i_reg_addr[6:2]] <= i_reg_wdata;
      end
      if (state_r == ST_CAP && blk) begin
        if (clane_c == 2'h0) begin
          genreg_r[creg_c] <= {i_mem_rdata, 24'h00_0000};
        end else begin
          genreg_r[creg_c][{~clane_c, 3'b000} +: 8] <= i_mem_rdata;
        end
      end
      if (state_r == ST_FIN && !is_st && !blk) begin
        genreg_r[rt_r] <= (op_r == lse_pkg::OP_LD_HA)
                        ? sign_extend_op(acc_r[15:0]) : acc_r;
      end
      if (state_r == ST_FIN && upd_r) begin
        genreg_r[ra_r] <= ea_r;
      end
    end
  end

  // Exception register, condition field zero and reservation flag.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      so_r  <= 1'b0;
      cnt_r <= lse_pkg::CNT_RST;
      cond_zero_r <= lse_pkg::COND_ZERO_RST;
      rsv_r <= 1'b0;
    end else begin
      if (i_reg_wr && i_reg_addr == lse_pkg::REG_EXCEPTION) begin
        so_r  <= i_reg_wdata[lse_pkg::EXCEPTION_SO_POS];
        cnt_r <= i_reg_wdata[6:0];
      end
      if (i_reg_wr && i_reg_addr == lse_pkg::REG_COND_ZERO) begin
        cond_zero_r <= i_reg_wdata[3:0];
      end
      if (i_reg_wr && i_reg_addr == lse_pkg::REG_STAT) begin
        rsv_r <= i_reg_wdata[lse_pkg::STAT_RSV_POS];
      end
      if (state_r == ST_FIN && op_r == lse_pkg::OP_LD_RSV) begin
        rsv_r <= 1'b1;
      end
      if (state_r == ST_FIN && op_r == lse_pkg::OP_ST_COND) begin
        rsv_r <= 1'b0;
        cond_zero_r <= {2'b00, ok_r, so_r};
      end
    end
  end

  // Register read data, valid the cycle after the read strobe.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      rdata_r <= 32'h0000_0000;
      if (i_reg_addr[7] == 1'b0 && i_reg_addr[1:0] == 2'b00) begin
        rdata_r <= genreg_r[i_reg_addr[6:2]];
      end else if (i_reg_addr == lse_pkg::REG_EXCEPTION) begin
        rdata_r <= {so_r, 24'h00_0000, cnt_r};
      end else if (i_reg_addr == lse_pkg::REG_COND_ZERO) begin
        rdata_r <= {28'h000_0000, cond_zero_r};
      end else if (i_reg_addr == lse_pkg::REG_STAT) begin
        rdata_r[lse_pkg::STAT_RSV_POS]  <= rsv_r;
        rdata_r[lse_pkg::STAT_BUSY_POS] <= state_r != ST_IDLE;
      end
    end
  end

  // Handshake outputs.
  assign o_op_ready  = state_r == ST_IDLE;
  assign o_op_done   = state_r == ST_FIN;
  assign o_reg_rdata = rdata_r;

  // Checks on the sequencing and on register results.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_accept;
    o_op_ready && i_op_valid;
  endsequence
  sequence s_rd_cap;
    (o_mem_req && !o_mem_we) ##1 (state_r == ST_CAP);
  endsequence
  sequence s_fin(lse_pkg::lse_op_e op);
    state_r == ST_FIN && op_r == op && !upd_r;
  endsequence

  AST_EA_FORM: assert property (
    s_accept |-> ##2 (!o_mem_req || o_mem_addr == $past(ea_c, 2)))
    else $error("First byte address is not the effective address.");
  AST_ZERO_EXT: assert property (
    s_fin(lse_pkg::OP_LD_BZ) |=> genreg_r[rt_r][31:8] == 24'h00_0000)
    else $error("Byte load left upper bits set.");
  AST_SIGN_EXT: assert property (
    s_fin(lse_pkg::OP_LD_HA) |=> genreg_r[rt_r]
      == {{16{$past(acc_r[15])}}, $past(acc_r[15:0])})
    else $error("Halfword load not sign extended.");
  AST_UPDATE: assert property (
    (state_r == ST_FIN && upd_r) |=> genreg_r[ra_r] == $past(ea_r))
    else $error("Base register not updated with the address.");
  AST_REV_LOAD: assert property (
    s_rd_cap ##0 (op_r == lse_pkg::OP_LD_WREV && idx_r == 8'h00)
      |=> acc_r[7:0] == $past(i_mem_rdata))
    else $error("First reversed byte not in the low lane.");
  AST_REV_STORE: assert property (
    (o_mem_req && op_r == lse_pkg::OP_ST_WREV && idx_r == 8'h00)
      |-> o_mem_we && o_mem_wdata == genreg_r[rt_r][7:0])
    else $error("Reversed store did not send the low byte first.");
  AST_STORE_LOW: assert property (
    (o_mem_req && op_r == lse_pkg::OP_ST_B)
      |-> o_mem_wdata == genreg_r[rt_r][7:0])
    else $error("Byte store did not send the low byte.");
  AST_STR_COUNT: assert property (
    s_accept ##0 (i_op == lse_pkg::OP_LD_STR && !i_idx && i_nb == 5'h00)
      |=> n_r == lse_pkg::STR_ZERO_BYTES)
    else $error("Zero count field did not give 32 bytes.");
  AST_RSV_SET: assert property (
    s_fin(lse_pkg::OP_LD_RSV) |=> rsv_r)
    else $error("Reservation not set by load and reserve.");
  AST_COND: assert property (
    (state_r == ST_FIN && op_r == lse_pkg::OP_ST_COND)
      |=> !rsv_r && cond_zero_r == {2'b00, $past(ok_r), $past(so_r)})
    else $error("Conditional store result field wrong.");

endmodule // lse_load_store_exec
`default_nettype wire

/* logic/lse_pkg.sv */
/*
  Package of the load/store execution block: operation codes, register
  offsets, field positions, byte counts and reset values.
  Assumes one 200 MHz clock and a byte-wide memory port.
*/
`default_nettype none
package lse_pkg;

  // Operations accepted on the command port.
  typedef enum logic [4:0] {
    OP_LD_BZ, OP_LD_HZ, OP_LD_HA, OP_LD_W, OP_LD_HREV, OP_LD_WREV,
    OP_LD_RSV, OP_ST_B, OP_ST_H, OP_ST_W, OP_ST_HREV, OP_ST_WREV,
    OP_ST_COND, OP_LD_MULT, OP_ST_MULT, OP_LD_STR, OP_ST_STR
  } lse_op_e;

  // Register byte addresses; general register k sits at 4 * k.
  localparam logic [7:0]  REG_GENREG_BASE = 8'h00;
  localparam logic [7:0]  REG_EXCEPTION   = 8'h80;
  localparam logic [7:0]  REG_COND_ZERO   = 8'h84;
  localparam logic [7:0]  REG_STAT     = 8'h88;

  // Field positions.
  localparam logic [4:0]  EXCEPTION_SO_POS = 5'h1F;
  localparam logic [4:0]  STAT_RSV_POS  = 5'h00;
  localparam logic [4:0]  STAT_BUSY_POS = 5'h01;

  // Values after reset.
  localparam logic [31:0] GENREG_RST    = 32'h0000_0000;
  localparam logic [6:0]  CNT_RST       = 7'h00;
  localparam logic [3:0]  COND_ZERO_RST = 4'h0;

  // Byte counts and lane bases of single accesses, the zero-field string byte count and the number of general registers.
  localparam logic [7:0]  N_BYTE         = 8'h01;
  localparam logic [7:0]  N_HALF         = 8'h02;
  localparam logic [7:0]  N_WORD         = 8'h04;
  localparam logic [7:0]  STR_ZERO_BYTES = 8'h20;
  localparam logic [5:0]  NUM_GENREG     = 6'h20;
  localparam logic [1:0]  LANE_BYTE      = 2'h3;
  localparam logic [1:0]  LANE_HALF      = 2'h2;
  localparam logic [1:0]  LANE_WORD      = 2'h0;

endpackage
`default_nettype wire

/* testbench/lse_mem_model.sv */
/*
  Byte-wide memory model that answers the load/store block's memory port.
  Assumes one byte request per cycle and read data wanted one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module lse_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output var logic  [7:0]  o_rdata
);
  logic [7:0] mem [0:255];

  initial o_rdata = 8'h5a;

  // Reads answer in the next cycle only; otherwise the lines toggle so that
  // a late or early capture by the block shows up as wrong data.
  always @(posedge i_clk_sys) begin
    if (i_req && i_we)
      mem[i_addr[7:0]] <= i_wdata;
    if (i_req && !i_we)
      o_rdata <= mem[i_addr[7:0]];
    else
      o_rdata <= ~o_rdata;
  end
endmodule // lse_mem_model
`default_nettype wire

/* testbench/lse_load_store_exec_tb.sv */
/*
  Self-checking bench of the load/store block with a byte memory model.
  Assumes the package, the block and the memory model compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module lse_load_store_exec_tb;
  logic             clk, rst, op_valid, upd, idx, op_ready, op_done, u;
  logic             mem_req, mem_we, reg_wr, reg_rd;
  lse_pkg::lse_op_e op, o;
  logic [4:0]       rt, ra, rb, nb, a0;
  logic [15:0]      disp;
  logic [7:0]       mem_wdata, mem_rdata, reg_addr, s;
  logic [31:0]      mem_addr, reg_wdata, reg_rdata, seed, base, iv, ea, d, v;
  int               fails, checks, j, k, m, n;

  lse_load_store_exec lse_load_store_exec_i (
    .i_clk_sys(clk), .i_rst(rst), .i_op_valid(op_valid), .i_op(op),
    .i_upd(upd), .i_idx(idx), .i_rt(rt), .i_ra(ra), .i_rb(rb),
    .i_disp(disp), .i_nb(nb), .o_op_ready(op_ready), .o_op_done(op_done),
    .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));

  lse_mem_model lse_mem_model_i (
    .i_clk_sys(clk), .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr),
    .i_wdata(mem_wdata), .o_rdata(mem_rdata));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Xorshift source; the fixed seed keeps every run the same.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reads of the memory model's array and the expected results.
  function automatic logic [7:0] mb(logic [31:0] a);
    return lse_mem_model_i.mem[a[7:0]];
  endfunction
  function automatic logic [31:0] mw(logic [31:0] a);
    return {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)};
  endfunction
  function automatic logic [31:0] z(logic [7:0] b);
    return {24'h00_0000, b};
  endfunction
  function automatic logic [31:0] ld_exp(lse_pkg::lse_op_e t, logic [31:0] w);
    case (t)
      lse_pkg::OP_LD_BZ:   return {24'h00_0000, w[31:24]};
      lse_pkg::OP_LD_HZ:   return {16'h0000, w[31:16]};
      lse_pkg::OP_LD_HA:   return {{16{w[31]}}, w[31:16]};
      lse_pkg::OP_LD_HREV: return {16'h0000, w[23:16], w[31:24]};
      lse_pkg::OP_LD_WREV: return {w[7:0], w[15:8], w[23:16], w[31:24]};
      default:             return w;
    endcase
  endfunction
  function automatic logic [7:0] st_exp(lse_pkg::lse_op_e t, logic [31:0] w,
                                        int i);
    case (t)
      lse_pkg::OP_ST_B:    return w[7:0];
      lse_pkg::OP_ST_H:    return i ? w[7:0] : w[15:8];
      lse_pkg::OP_ST_HREV: return i ? w[15:8] : w[7:0];
      lse_pkg::OP_ST_WREV: return w[8*i +: 8];
      default:             return w[31-8*i -: 8];
    endcase
  endfunction

  // Comparison, verdict and bus tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic gchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic run(input lse_pkg::lse_op_e t, input logic up, input logic x,
                     input logic [4:0] tr, input logic [4:0] br,
                     input logic [15:0] dp, input logic [4:0] c);
    int i;
    @(posedge clk);
    op_valid <= 1'b1;
    op <= t;
    upd <= up;
    idx <= x;
    rt <= tr;
    ra <= br;
    rb <= 5'h09;
    disp <= dp;
    nb <= c;
    @(posedge clk);
    op_valid <= 1'b0;
    #1 chk({31'h0000_0000, op_ready}, 32'h0000_0000);
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (op_done === 1'b1)
        break;
    end
    if (i == 300) begin
      fails++;
      results();
    end
  endtask
  // Fresh base (register 5) and small index (register 9).
  task automatic prep();
    base = rnd();
    iv = rnd() & 32'h0000_00ff;
    wr(8'h14, base);
    wr(8'h24, iv);
  endtask

  // Main sequence: reset, register map, then every operation kind.
  initial begin
    {rst, op_valid, upd, idx, reg_wr, reg_rd} = 6'h01 << 5;
    {rt, ra, rb, nb, disp, reg_addr, reg_wdata} = '0;
    op = lse_pkg::OP_LD_BZ;
    seed = 32'h0000_950c;
    fails = 0;
    checks = 0;
    for (k = 0; k < 256; k++) begin
      v = rnd();
      lse_mem_model_i.mem[k] = v[7:0];
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    gchk(8'h1c, lse_pkg::GENREG_RST);
    gchk(lse_pkg::REG_EXCEPTION, 32'h0000_0000);
    gchk(lse_pkg::REG_COND_ZERO, 32'h0000_0000);
    gchk(lse_pkg::REG_STAT, 32'h0000_0000);
    wr(8'h90, 32'hffff_ffff);
    gchk(8'h90, 32'h0000_0000);
    for (j = 0; j < 14; j++) begin
      o = lse_pkg::lse_op_e'(j % 7);
      u = (j >= 7) && (o != lse_pkg::OP_LD_RSV);
      prep();
      v = rnd();
      a0 = (j == 2) ? 5'h00 : 5'h05;
      ea = ((a0 != 5'h00) ? base : 32'h0000_0000) +
           (j[0] ? iv : {{16{v[15]}}, v[15:0]});
      run(o, u, j[0], 5'h07, a0, v[15:0], 5'h00);
      gchk(8'h1c, ld_exp(o, mw(ea)));
      if (u)
        gchk(8'h14, ea);
    end
    gchk(lse_pkg::REG_STAT, 32'h0000_0001);
    for (j = 0; j < 10; j++) begin
      o = lse_pkg::lse_op_e'(7 + j % 5);
      prep();
      d = rnd();
      wr(8'h0c, d);
      v = rnd();
      ea = base + (j[0] ? iv : {{16{v[15]}}, v[15:0]});
      n = (o == lse_pkg::OP_ST_B) ? 1 :
          (o == lse_pkg::OP_ST_H || o == lse_pkg::OP_ST_HREV) ? 2 : 4;
      s = mb(ea + n);
      run(o, j >= 5, j[0], 5'h03, 5'h05, v[15:0], 5'h00);
      for (k = 0; k < n; k++)
        chk(z(mb(ea + k)), z(st_exp(o, d, k)));
      chk(z(mb(ea + n)), z(s));
      if (j >= 5)
        gchk(8'h14, ea);
    end
    for (j = 0; j < 2; j++) begin
      prep();
      ea = base + iv;
      wr(lse_pkg::REG_EXCEPTION, {j[0], 31'h0000_0000});
      run(lse_pkg::OP_LD_RSV, 1'b0, 1'b1, 5'h07, 5'h05, 16'h0000, 5'h00);
      for (k = 0; k < 2; k++) begin
        d = rnd();
        wr(8'h0c, d);
        run(lse_pkg::OP_ST_COND, 1'b0, 1'b1, 5'h03, 5'h05, 16'h0000, 5'h00);
        if (k == 0)
          v = d;
        chk(mw(ea), v);
        gchk(lse_pkg::REG_COND_ZERO, {28'h000_0000, 2'h0, k == 0, j[0]});
        gchk(lse_pkg::REG_STAT, 32'h0000_0000);
      end
    end
    wr(lse_pkg::REG_EXCEPTION, 32'h0000_0000);
    prep();
    run(lse_pkg::OP_LD_MULT, 1'b0, 1'b0, 5'h1d, 5'h05, 16'h0010, 5'h00);
    for (k = 0; k < 3; k++)
      gchk(8'(4 * (29 + k)), mw(base + 32'h0000_0010 + 4 * k));
    gchk(8'h14, base);
    d = rnd();
    v = rnd();
    wr(8'h78, d);
    wr(8'h7c, v);
    run(lse_pkg::OP_ST_MULT, 1'b0, 1'b0, 5'h1e, 5'h05, 16'hfff0, 5'h00);
    chk(mw(base - 32'h0000_0010), d);
    chk(mw(base - 32'h0000_000c), v);
    run(lse_pkg::OP_LD_STR, 1'b0, 1'b0, 5'h1f, 5'h05, 16'h0000, 5'h05);
    gchk(8'h7c, mw(base));
    gchk(8'h00, {mb(base + 4), 24'h00_0000});
    gchk(8'h14, base);
    wr(8'h48, 32'h5a5a_5a5a);
    run(lse_pkg::OP_LD_STR, 1'b0, 1'b0, 5'h0a, 5'h05, 16'h0000, 5'h00);
    for (k = 0; k < 8; k++)
      gchk(8'(40 + 4 * k), mw(base + 4 * k));
    gchk(8'h48, 32'h5a5a_5a5a);
    ea = base + iv;
    wr(lse_pkg::REG_EXCEPTION, 32'h0000_0003);
    run(lse_pkg::OP_LD_STR, 1'b0, 1'b1, 5'h14, 5'h05, 16'h0000, 5'h00);
    gchk(8'h50, {mb(ea), mb(ea + 1), mb(ea + 2), 8'h00});
    gchk(8'h24, iv);
    wr(lse_pkg::REG_EXCEPTION, 32'h0000_0000);
    wr(8'h50, 32'hc3c3_c3c3);
    run(lse_pkg::OP_LD_STR, 1'b0, 1'b1, 5'h14, 5'h05, 16'h0000, 5'h00);
    gchk(8'h50, 32'hc3c3_c3c3);
    wr(lse_pkg::REG_EXCEPTION, 32'h0000_0006);
    d = rnd();
    v = rnd();
    wr(8'h0c, d);
    wr(8'h10, v);
    s = mb(ea + 6);
    run(lse_pkg::OP_ST_STR, 1'b0, 1'b1, 5'h03, 5'h05, 16'h0000, 5'h00);
    chk(mw(ea), d);
    chk({mb(ea + 4), mb(ea + 5), mb(ea + 6)}, {v[31:16], s});
    results();
  end
endmodule // lse_load_store_exec_tb
`default_nettype wire
